/* File: design/led_backlight_start_fault_ctrl.sv */
// Summary of operation
// - Start only while enable is high and supply is above lockout, first assessing every channel's status.
// - After assessment, reset the duty, short-off and fault flag logic to defaults; the assessed open status is kept.
// - A bus stop from the host triggers a dimming duty check followed by soft-start.
// - A shorted string seen in the run state turns off only its own channel driver; shorts during soft-start are not latched.
// - An open string turns off its driver, which comes back by itself when the open clears.
// - An output-to-ground or diode short sets a fault flag readable over the bus.
// - The host clears the fault flag with a bus command, unless a fault is present in that same cycle.
// - The fault pin goes high the cycle after a fault is present while powered, and stays high while the flag is set.
// - Four independent channel drivers each with its own enable.
`timescale 1ns/1ps
`default_nettype none

module led_backlight_start_fault_ctrl #(
    parameter logic [6:0] BUS_ADDR = led_bl_pkg::BUS_ADDR_DEFAULT
) (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_reset_n,
    // Power and control
    input  wire logic                  i_enable,
    input  wire logic                  i_supply_ok,
    input  wire logic                  i_dim_pwm,
    // Protection sense
    input  wire led_bl_pkg::ch_sense_t i_ch_sense,
    input  wire logic                  i_vout_short,
    input  wire logic                  i_diode_short,
    // Management bus pins
    input  wire logic                  i_mgmt_bus_clock_pin,
    input  wire logic                  i_mgmt_bus_data_pin,
    output logic                       o_mgmt_bus_data_pin,
    output logic                       o_mgmt_bus_data_pin_oe,
    // Channel drivers and status
    output led_bl_pkg::led_sink_t      o_led_sink,
    output logic                       o_fault,
    output logic                       o_soft_start,
    output logic                       o_running,
    output logic [7:0]                 o_dim_duty,
    output logic [3:0]                 o_assessed_open
);

    // ========================================================
    // Main sequence
    // ========================================================
    led_bl_pkg::main_st_t st_r;
    logic [led_bl_pkg::TMR_W-1:0] tmr_r;
    logic [8:0] high_cnt_r;
    logic [8:0] high_sum;
    logic       stop_pulse;
    logic       clear_pulse;
    logic       powered;
    logic       init_now;
    assign powered  = i_enable & i_supply_ok;
    assign init_now = (st_r == led_bl_pkg::ST_INIT);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r  <= led_bl_pkg::ST_OFF;
            tmr_r <= '0;
        end else if (!powered) begin
            st_r  <= led_bl_pkg::ST_OFF;
            tmr_r <= '0;
        end else begin
            case (st_r)
                led_bl_pkg::ST_OFF:    st_r <= led_bl_pkg::ST_ASSESS;
                led_bl_pkg::ST_ASSESS: st_r <= led_bl_pkg::ST_INIT;
                led_bl_pkg::ST_INIT:   st_r <= led_bl_pkg::ST_WAIT;
                led_bl_pkg::ST_WAIT:
                    if (stop_pulse) st_r <= led_bl_pkg::ST_DUTY;
                led_bl_pkg::ST_DUTY: begin
                    if (tmr_r == led_bl_pkg::TMR_W'(
                            led_bl_pkg::DUTY_CYCLES - 1)) begin
                        tmr_r <= '0;
                        st_r  <= led_bl_pkg::ST_SOFT;
                    end else begin
                        tmr_r <= tmr_r + 1'b1;
                    end
                end
                led_bl_pkg::ST_SOFT: begin
                    if (tmr_r == led_bl_pkg::TMR_W'(
                            led_bl_pkg::SS_CYCLES - 1)) begin
                        st_r <= led_bl_pkg::ST_RUN;
                    end else begin
                        tmr_r <= tmr_r + 1'b1;
                    end
                end
                led_bl_pkg::ST_RUN:    st_r <= led_bl_pkg::ST_RUN;
                default:               st_r <= led_bl_pkg::ST_OFF;
            endcase
        end
    end

    // ========================================================
    // Dimming duty measurement
    // ========================================================
    // Duty is high-time over a fixed window, saturated to 8 bits
    assign high_sum = high_cnt_r + {8'h00, i_dim_pwm};
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            high_cnt_r <= '0;
            o_dim_duty <= '0;
        end else if (init_now) begin
            high_cnt_r <= '0;
            o_dim_duty <= '0;
        end else if (st_r == led_bl_pkg::ST_DUTY) begin
            if (tmr_r == led_bl_pkg::TMR_W'(
                    led_bl_pkg::DUTY_CYCLES - 1)) begin
                o_dim_duty <= high_sum[8] ? led_bl_pkg::DUTY_FULL
                                          : high_sum[7:0];
            end
            high_cnt_r <= high_sum;
        end else begin
            high_cnt_r <= '0;
        end
    end

    // ========================================================
    // Channel assessment and protection
    // ========================================================
    logic [3:0] short_off_r;
    logic [3:0] sink_en;
    logic       drive_on;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_assessed_open <= '0;
        end else if (st_r == led_bl_pkg::ST_ASSESS) begin
            o_assessed_open <= i_ch_sense.open;
        end
    end

    // A short stays off until the next power-up, unlike an open
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            short_off_r <= '0;
        end else if (init_now || !powered) begin
            short_off_r <= '0;
        end else if (st_r == led_bl_pkg::ST_RUN) begin
            short_off_r <= short_off_r | i_ch_sense.shorted;
        end
    end

    assign drive_on = (st_r == led_bl_pkg::ST_SOFT) ||
                      (st_r == led_bl_pkg::ST_RUN);
    // Open masks the driver only while it persists
    assign sink_en  = drive_on ? (~short_off_r & ~i_ch_sense.open)
                               : led_bl_pkg::CH_ALL_OFF;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_led_sink   <= '0;
            o_soft_start <= 1'h0;
            o_running    <= 1'h0;
        end else begin
            o_led_sink   <= led_bl_pkg::led_sink_t'(sink_en);
            o_soft_start <= (st_r == led_bl_pkg::ST_SOFT);
            o_running    <= (st_r == led_bl_pkg::ST_RUN);
        end
    end

    // ========================================================
    // Fault flag and pin
    // ========================================================
    logic fault_flag_r;
    logic fault_now;
    assign fault_now = powered & (i_vout_short | i_diode_short);
    // Set wins over a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fault_flag_r <= 1'h0;
            o_fault      <= 1'h0;
        end else begin
            o_fault <= fault_now | fault_flag_r;
            if (fault_now) begin
                fault_flag_r <= 1'h1;
            end else if (clear_pulse || init_now) begin
                fault_flag_r <= 1'h0;
            end
        end
    end

    // ========================================================
    // Management bus slave
    // ========================================================
    led_bl_pkg::bus_st_t bst_r;
    led_bl_pkg::status_byte_t status;
    logic       scl_q;
    logic       sda_q;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [3:0] cnt_r;
    logic       rw_r;
    logic       nack_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;

    assign scl_rise   = i_mgmt_bus_clock_pin & ~scl_q;
    assign scl_fall   = ~i_mgmt_bus_clock_pin & scl_q;
    assign start_c    = i_mgmt_bus_clock_pin & scl_q & sda_q &
                        ~i_mgmt_bus_data_pin;
    assign stop_pulse = i_mgmt_bus_clock_pin & scl_q & ~sda_q &
                        i_mgmt_bus_data_pin;
    assign clear_pulse = scl_fall && (bst_r == led_bl_pkg::B_WRITE) &&
                         (cnt_r == led_bl_pkg::BITS_PER_BYTE) &&
                         (shift_r == led_bl_pkg::CMD_CLEAR_FAULT);
    assign status = led_bl_pkg::status_byte_t'({fault_flag_r,
        (st_r == led_bl_pkg::ST_RUN), 2'h0, short_off_r});
    assign o_mgmt_bus_data_pin = 1'h0;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
        end else begin
            scl_q <= i_mgmt_bus_clock_pin;
            sda_q <= i_mgmt_bus_data_pin;
        end
    end

    // Data pin changes only after a clock fall, so no false start/stop
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bst_r   <= led_bl_pkg::B_IDLE;
            shift_r <= '0;
            tx_r    <= '0;
            cnt_r   <= '0;
            rw_r    <= 1'h0;
            nack_r  <= 1'h0;
            o_mgmt_bus_data_pin_oe <= 1'h0;
        end else if (stop_pulse || !powered) begin
            bst_r <= led_bl_pkg::B_IDLE;
            o_mgmt_bus_data_pin_oe <= 1'h0;
        end else if (start_c) begin
            bst_r <= led_bl_pkg::B_ADDR;
            cnt_r <= '0;
            o_mgmt_bus_data_pin_oe <= 1'h0;
        end else if (scl_rise) begin
            case (bst_r)
                led_bl_pkg::B_ADDR, led_bl_pkg::B_WRITE: begin
                    shift_r <= {shift_r[6:0], i_mgmt_bus_data_pin};
                    cnt_r   <= cnt_r + 1'b1;
                end
                led_bl_pkg::B_READ:   cnt_r  <= cnt_r + 1'b1;
                led_bl_pkg::B_ACK_RD: nack_r <= i_mgmt_bus_data_pin;
                default:              cnt_r  <= cnt_r;
            endcase
        end else if (scl_fall) begin
            case (bst_r)
                led_bl_pkg::B_ADDR: begin
                    if (cnt_r == led_bl_pkg::BITS_PER_BYTE) begin
                        if (shift_r[7:1] == BUS_ADDR) begin
                            rw_r  <= shift_r[0];
                            bst_r <= led_bl_pkg::B_ACK_AD;
                            o_mgmt_bus_data_pin_oe <= 1'h1;
                        end else begin
                            bst_r <= led_bl_pkg::B_IDLE;
                        end
                    end
                end
                led_bl_pkg::B_ACK_AD, led_bl_pkg::B_ACK_RD,
                led_bl_pkg::B_ACK_WR: begin
                    cnt_r <= '0;
                    if (bst_r == led_bl_pkg::B_ACK_RD && nack_r) begin
                        bst_r <= led_bl_pkg::B_IDLE;
                        o_mgmt_bus_data_pin_oe <= 1'h0;
                    end else if (rw_r) begin
                        bst_r <= led_bl_pkg::B_READ;
                        tx_r  <= {status[6:0], 1'h0};
                        o_mgmt_bus_data_pin_oe <= ~status[7];
                    end else begin
                        bst_r <= led_bl_pkg::B_WRITE;
                        o_mgmt_bus_data_pin_oe <= 1'h0;
                    end
                end
                led_bl_pkg::B_WRITE: begin
                    if (cnt_r == led_bl_pkg::BITS_PER_BYTE) begin
                        bst_r <= led_bl_pkg::B_ACK_WR;
                        o_mgmt_bus_data_pin_oe <= 1'h1;
                    end
                end
                led_bl_pkg::B_READ: begin
                    if (cnt_r == led_bl_pkg::BITS_PER_BYTE) begin
                        bst_r <= led_bl_pkg::B_ACK_RD;
                        o_mgmt_bus_data_pin_oe <= 1'h0;
                    end else begin
                        tx_r <= {tx_r[6:0], 1'h0};
                        o_mgmt_bus_data_pin_oe <= ~tx_r[7];
                    end
                end
                default: bst_r <= led_bl_pkg::B_IDLE;
            endcase
        end
    end

endmodule // led_backlight_start_fault_ctrl

`default_nettype wire

/* File: design/led_bl_pkg.sv */
`default_nettype none

package led_bl_pkg;

    // ========================================================
    // Timing
    // ========================================================
    localparam int CLK_PERIOD_NS  = 10;
    localparam int SS_TIME_NS     = 10000;
    localparam int SS_CYCLES      =
        (SS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DUTY_WINDOW_NS = 2560;
    localparam int DUTY_CYCLES    = DUTY_WINDOW_NS / CLK_PERIOD_NS;
    localparam int TMR_W          = 16;

    // ========================================================
    // Management bus, duty and channel constants
    // ========================================================
    localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h2C;
    localparam logic [7:0] CMD_CLEAR_FAULT  = 8'h01;
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
    localparam logic [7:0] DUTY_FULL        = 8'hFF;
    localparam logic [3:0] CH_ALL_OFF       = 4'h0;

    // ========================================================
    // Carriers
    // ========================================================
    typedef struct packed {
        logic [3:0] shorted;
        logic [3:0] open;
    } ch_sense_t;

    typedef struct packed {
        logic led_sink_ch4;
        logic led_sink_ch3;
        logic led_sink_ch2;
        logic led_sink_ch1;
    } led_sink_t;

    typedef struct packed {
        logic       fault;
        logic       running;
        logic [1:0] rsvd;
        logic [3:0] short_off;
    } status_byte_t;

    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_ASSESS = 3'b001,
        ST_INIT   = 3'b010,
        ST_WAIT   = 3'b011,
        ST_DUTY   = 3'b100,
        ST_SOFT   = 3'b101,
        ST_RUN    = 3'b110
    } main_st_t;

    typedef enum logic [2:0] {
        B_IDLE   = 3'b000,
        B_ADDR   = 3'b001,
        B_ACK_AD = 3'b010,
        B_WRITE  = 3'b011,
        B_ACK_WR = 3'b100,
        B_READ   = 3'b101,
        B_ACK_RD = 3'b110
    } bus_st_t;

endpackage

`default_nettype wire

/* File: verification/led_bl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Port checker
// ============================================================
module led_bl_asserts (
    input wire logic                  i_clk,
    input wire logic                  i_reset_n,
    input wire logic                  i_enable,
    input wire logic                  i_supply_ok,
    input wire led_bl_pkg::ch_sense_t i_ch_sense,
    input wire logic                  i_vout_short,
    input wire logic                  i_diode_short,
    input wire logic                  o_mgmt_bus_data_pin,
    input wire led_bl_pkg::led_sink_t o_led_sink,
    input wire logic                  o_fault,
    input wire logic                  o_soft_start,
    input wire logic                  o_running
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // Soft start is too long for a delay range, so its cycles are counted
    logic [10:0] ss_cnt_r;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ss_cnt_r <= 11'h000;
        end else if (o_soft_start) begin
            ss_cnt_r <= ss_cnt_r + 11'h001;
        end else begin
            ss_cnt_r <= 11'h000;
        end
    end

    power_gate_a: assert property (
        !(i_enable && i_supply_ok) |-> ##2 !o_running && !o_soft_start)
        else $error("output active without power");
    sink_idle_a: assert property (
        !o_soft_start && !o_running |-> o_led_sink == led_bl_pkg::CH_ALL_OFF)
        else $error("sink on before soft start");
    soft_len_a: assert property (
        $fell(o_soft_start) && o_running |->
            ss_cnt_r == 11'(led_bl_pkg::SS_CYCLES))
        else $error("soft start length wrong");
    soft_max_a: assert property (
        ss_cnt_r <= 11'(led_bl_pkg::SS_CYCLES))
        else $error("soft start overran");
    run_after_a: assert property (
        $rose(o_running) |-> $past(o_soft_start))
        else $error("run without soft start");
    fault_pin_a: assert property (
        i_enable && i_supply_ok && (i_vout_short || i_diode_short)
        |=> o_fault) else $error("fault pin not raised");
    open_off_a: assert property (
        o_running && i_ch_sense.open[0] |=> !o_led_sink.led_sink_ch1)
        else $error("open channel still driven");
    short_off_a: assert property (
        o_running && (i_ch_sense.shorted != 4'h0) |->
            ##2 ((o_led_sink & $past(i_ch_sense.shorted, 2)) == 4'h0))
        else $error("shorted channel still driven");
    data_low_a: assert property (
        o_mgmt_bus_data_pin == 1'b0) else $error("data pin driven high");
endmodule // led_bl_asserts

bind led_backlight_start_fault_ctrl led_bl_asserts u_asserts (
    .i_clk, .i_reset_n, .i_enable, .i_supply_ok, .i_ch_sense, .i_vout_short,
    .i_diode_short, .o_mgmt_bus_data_pin, .o_led_sink, .o_fault,
    .o_soft_start, .o_running);

`default_nettype wire

/* File: verification/mgmt_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Bus host; both lines pulled up, clock stands high when idle
// ============================================================
module mgmt_host_model #(
    parameter int HALF = 4
) (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic tick();
        repeat (HALF) @(posedge i_clk);
    endtask
    // Data moves only well after the clock fall, never beside it
    task automatic bit_io(input logic b, output logic s);
        tick();
        o_sda <= b;
        tick();
        o_scl <= 1'b1;
        tick();
        s = i_sda;
        tick();
        o_scl <= 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] tx, input logic mack,
                           output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(mack, ack);
    endtask
    task automatic frame(input logic [6:0] a, input logic rd,
                         input logic [7:0] tx, output logic [7:0] rx,
                         output logic nack);
        logic [7:0] r0;
        logic       n2;
        o_sda <= 1'b0;
        tick();
        o_scl <= 1'b0;
        byte_io({a, rd}, 1'b1, r0, nack);
        byte_io(tx, 1'b1, rx, n2);
        if (!rd) nack = nack | n2;
        tick();
        o_sda <= 1'b0;
        tick();
        o_scl <= 1'b1;
        tick();
        o_sda <= 1'b1;
        tick();
    endtask
endmodule // mgmt_host_model

`default_nettype wire

/* File: verification/led_backlight_start_fault_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module led_backlight_start_fault_ctrl_tb_top;
    localparam logic [6:0] ADDR = led_bl_pkg::BUS_ADDR_DEFAULT;
    logic                  clk         = 1'b0;
    logic                  reset_n     = 1'b0;
    logic                  enable      = 1'b1;
    logic                  supply_ok   = 1'b1;
    logic                  dim_pwm     = 1'b0;
    logic [3:0]            pwm_cnt     = 4'h0;
    logic [3:0]            duty_h      = 4'h0;
    led_bl_pkg::ch_sense_t ch_sense    = '0;
    logic                  vout_short  = 1'b0;
    logic                  diode_short = 1'b0;
    logic                  scl;
    logic                  host_sda;
    logic                  sda_oe;
    logic                  sda_w;
    led_bl_pkg::led_sink_t led_sink;
    logic                  fault;
    logic                  soft_start;
    logic                  running;
    logic [7:0]            dim_duty;
    logic [3:0]            assessed_open;
    int                    failures    = 0;
    int                    cmp_count   = 0;

    assign sda_w = host_sda & ~sda_oe;
    always #5 clk = ~clk;
    // ========================================================
    // Dimming source: h high cycles in every 16
    // ========================================================
    always_ff @(posedge clk) begin
        pwm_cnt <= pwm_cnt + 4'h1;
        dim_pwm <= (pwm_cnt < duty_h);
    end

    led_backlight_start_fault_ctrl u_dut (
        .i_clk(clk), .i_reset_n(reset_n), .i_enable(enable),
        .i_supply_ok(supply_ok), .i_dim_pwm(dim_pwm), .i_ch_sense(ch_sense),
        .i_vout_short(vout_short), .i_diode_short(diode_short),
        .i_mgmt_bus_clock_pin(scl), .i_mgmt_bus_data_pin(sda_w),
        .o_mgmt_bus_data_pin(), .o_mgmt_bus_data_pin_oe(sda_oe),
        .o_led_sink(led_sink), .o_fault(fault), .o_soft_start(soft_start),
        .o_running(running), .o_dim_duty(dim_duty),
        .o_assessed_open(assessed_open));
    mgmt_host_model u_host (
        .i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(host_sda));

    // ========================================================
    // Shared tasks
    // ========================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Soft start plus duty window is about 1300 cycles
    task automatic wait_run();
        int k = 0;
        while (running !== 1'b1 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        if (running !== 1'b1) failures++;
    endtask
    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ========================================================
    // Scenarios
    // ========================================================
    initial begin
        logic [7:0] st;
        logic       nack;
        int         ch;
        void'($urandom(32'hdbb0));
        ch_sense <= {4'h0, 4'($urandom())};
        cyc(16);
        reset_n <= 1'b1;
        cyc(6);
        check({4'h0, assessed_open}, {4'h0, ch_sense.open});
        ch_sense <= '0;
        duty_h <= 4'($urandom_range(15, 1));
        cyc(40);
        check({7'h0, running}, 8'h00);
        u_host.frame(ADDR, 1'b0, 8'h00, st, nack);
        wait_run();
        check({7'h0, nack}, 8'h00);
        check(dim_duty, {duty_h, 4'h0});
        check({4'h0, led_sink}, 8'h0f);
        $display("start test done");
        for (ch = 0; ch < 4; ch++) begin
            ch_sense.open <= 4'h1 << ch;
            cyc(3);
            check({4'h0, led_sink}, {4'h0, ~(4'h1 << ch)});
            ch_sense.open <= 4'h0;
            cyc(3);
            check({4'h0, led_sink}, 8'h0f);
        end
        $display("open test done");
        for (int k = 0; k < 2; k++) begin
            if (k == 0) vout_short <= 1'b1;
            else diode_short <= 1'b1;
            cyc(2);
            check({7'h0, fault}, 8'h01);
            vout_short <= 1'b0;
            diode_short <= 1'b0;
            cyc(3);
            u_host.frame(ADDR + 7'h1, 1'b0, 8'h01, st, nack);
            check({7'h0, nack}, 8'h01);
            check({7'h0, fault}, 8'h01);
            u_host.frame(ADDR, 1'b1, 8'hff, st, nack);
            check(st, 8'hc0);
            u_host.frame(ADDR, 1'b0, 8'h01, st, nack);
            check({7'h0, fault}, 8'h00);
        end
        $display("fault test done");
        ch = $urandom_range(3, 0);
        ch_sense.shorted <= 4'h1 << ch;
        cyc(3);
        ch_sense.shorted <= 4'h0;
        cyc(3);
        check({4'h0, led_sink}, {4'h0, ~(4'h1 << ch)});
        u_host.frame(ADDR, 1'b1, 8'hff, st, nack);
        check(st, {4'h4, 4'h1 << ch});
        $display("short test done");
        supply_ok <= 1'b0;
        cyc(3);
        check({3'h0, running, led_sink}, 8'h00);
        supply_ok <= 1'b1;
        cyc(8);
        check({7'h0, running}, 8'h00);
        u_host.frame(ADDR, 1'b0, 8'h00, st, nack);
        wait_run();
        check({3'h0, running, led_sink}, 8'h1f);
        $display("restart test done");
        stop_test();
    end
    // Whole run needs about 5400 cycles
    initial begin
        cyc(60000);
        failures++;
        stop_test();
    end
endmodule // led_backlight_start_fault_ctrl_tb_top

`default_nettype wire
